// ==== testbench/asd_queue_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// prefetch queue seen from the decoder
// ----------------------------------------------------------------
module asd_queue_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic slow,
  input wire logic queueTake,
  output logic [7:0] queueByte,
  output logic queueValid
);
  logic [7:0] fifo[$];
  logic [7:0] lastByte;
  logic offering;
  logic liveQ;
  int stallCount;

  initial begin
    queueByte = 8'h00;
    queueValid = 1'b0;
    lastByte = 8'h00;
    offering = 1'b0;
    liveQ = 1'b0;
    stallCount = 0;
  end

  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask : push

  function automatic int depth();
    return fifo.size();
  endfunction : depth

  // a byte leaves only on an enabled edge where take meets an offered byte
  always @(posedge core_clk) begin
    liveQ <= reset_n;
    if (reset_n && clk_en && queueTake && offering && fifo.size() > 0) begin
      lastByte = fifo.pop_front();
      offering = 1'b0;
      stallCount = 0;
    end
  end

  // once offered, a byte stands until taken; an idle line alternates between all ones and the last byte taken
  always @(negedge core_clk) begin
    if (!offering && liveQ && fifo.size() > 0) begin
      if (!slow || stallCount >= 3) begin
        offering = 1'b1;
      end else begin
        stallCount++;
      end
    end
    queueValid = offering;
    queueByte = offering ? fifo[0] : ~queueByte ^ lastByte;
  end
endmodule : asd_queue_model

// ==== testbench/test_arith_segment_decoder.sv ====
`timescale 1ns/1ps
module test_arith_segment_decoder;
  import asd_pkg::*;

  typedef struct {
    asd_op_type op;
    asd_seg_type seg;
    logic chkSeg;
    logic full;
    logic chkD;
    logic w;
    logic d;
    logic mem;
    logic [7:0] form;
    logic [15:0] imm;
    logic [15:0] immMask;
    logic [5:0] cycW;
    logic [5:0] cycN;
  } asd_exp_type;

  localparam logic [7:0] PFX[4] = '{8'h2e, 8'h36, 8'h3e, 8'h26};
  localparam asd_seg_type PFX_SEG[4] = '{ASD_ONE_HOT_SEG_CODE, ASD_SEG_STACK, ASD_SEG_DATA,
                                         ASD_SEG_EXTRA};
  localparam logic [5:0] RM_BASE[4] = '{6'b000000, 6'b000100, 6'b001010, 6'b000110};
  localparam logic [6:0] ACC_BASE[4] = '{7'b0000010, 7'b0001010, 7'b0010110, 7'b0001110};
  localparam logic [2:0] IMM_SEL[4] = '{3'b000, 3'b010, 3'b101, 3'b011};
  localparam asd_op_type ARITH_OP[4] = '{ASD_SUM, ASD_SUM_CARRY, ASD_DIFFERENCE,
                                         ASD_DIFFERENCE_WITH_BORROW};
  localparam logic [7:0] ADJ[4] = '{8'h37, 8'h27, 8'h3f, 8'h2f};
  localparam asd_op_type ADJ_OP[4] = '{ASD_ASCII_ADJUST_AFTER_SUM, ASD_DECIMAL_ADJUST_AFTER_SUM,
    ASD_ASCII_ADJUST_AFTER_DIFFERENCE, ASD_DECIMAL_ADJUST_AFTER_DIFFERENCE};
  localparam logic [5:0] ADJ_CYC[4] = '{6'd8, 6'd4, 6'd7, 6'd4};

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic slow = 1'b0;
  int numErrors = 0;
  int samplesChecked = 0;
  int nBytes = 0;
  logic [31:0] lfsrState = 32'hc28d;
  asd_exp_type expList[$];

  always #20 core_clk = ~core_clk;

  function automatic logic [31:0] rnd();
    lfsrState = {lfsrState[30:0], 1'b0} ^ (lfsrState[31] ? 32'h04c11db7 : 32'h0);
    return lfsrState;
  endfunction : rnd

  task automatic cmp_val(input string what, input logic [15:0] expv, input logic [15:0] got);
    samplesChecked++;
    if (got !== expv) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", what, expv, got);
    end
  endtask : cmp_val

  // ----------------------------------------------------------------
  // both bus variants decode the same byte stream side by side
  // ----------------------------------------------------------------
  for (genvar gv = 0; gv < 2; gv++) begin : var_g
    logic [7:0] queueByte;
    logic queueValid;
    logic queueTake;
    logic instrValid;
    asd_op_type instrOp;
    asd_seg_type segOverride;
    logic wordOperand;
    logic regIsDest;
    logic memOperand;
    logic [7:0] formByte;
    logic [15:0] immData;
    logic [5:0] execCycles;
    logic execDone;
    int idx = 0;
    int cnt = 0;
    int takes = 0;
    logic running = 1'b0;
    logic [5:0] cycExp = 6'd0;
    asd_exp_type e;

    asd_queue_model qm (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clkEn), .slow(slow),
      .queueTake(queueTake), .queueByte(queueByte), .queueValid(queueValid));

    asd_arith_segment_decoder #(.NARROW_BUS(gv == 1)) DUT (.core_clk(core_clk),
      .reset_n(reset_n), .clk_en(clkEn), .queueByte(queueByte), .queueValid(queueValid),
      .queueTake(queueTake), .instrValid(instrValid), .instrOp(instrOp),
      .segOverride(segOverride), .wordOperand(wordOperand), .regIsDest(regIsDest),
      .memOperand(memOperand), .formByte(formByte), .immData(immData),
      .execCycles(execCycles), .execDone(execDone));

    // frozen edges are skipped so a stretched pulse is seen once
    always @(posedge core_clk) begin
      if (reset_n && clkEn) begin
        if (running) cnt++;
        if (queueTake) takes++;
        if (execDone) begin
          cmp_val("execDone_gap", 16'(cycExp), 16'(cnt));
          running = 1'b0;
        end
        if (instrValid) begin
          cmp_val("overlap", 16'h0, 16'(running));
          if (idx < expList.size()) begin
            e = expList[idx];
            cycExp = (gv == 1) ? e.cycN : e.cycW;
            cmp_val("instrOp", 16'(e.op), 16'(instrOp));
            if (e.chkSeg) cmp_val("segOverride", 16'(e.seg), 16'(segOverride));
            if (e.full) begin
              cmp_val("wordOperand", 16'(e.w), 16'(wordOperand));
              cmp_val("memOperand", 16'(e.mem), 16'(memOperand));
              cmp_val("formByte", 16'(e.form), 16'(formByte));
              cmp_val("immData", e.imm, immData & e.immMask);
            end
            if (e.chkD) cmp_val("regIsDest", 16'(e.d), 16'(regIsDest));
            cmp_val("execCycles", 16'(cycExp), 16'(execCycles));
            idx++;
          end else begin
            cmp_val("extra_instr", 16'h0, 16'h1);
          end
          cnt = 0;
          running = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // instruction builder and main sequence
  // ----------------------------------------------------------------
  task automatic add_instr(input int kind, input int sub, input logic w, input logic mem,
                           input logic [31:0] r);
    logic [7:0] b[$];
    asd_exp_type e;
    logic [1:0] md;
    logic s;
    md = !mem ? 2'b11 : (r[7:6] == 2'b11 ? 2'b01 : r[7:6]);
    s = r[24] & w;
    e = '{op: ASD_NONE, seg: ASD_SEG_NONE, chkSeg: (kind > 0 && kind < 6), full: 1'b1,
          chkD: 1'b0, w: w, d: r[25], mem: mem, form: {md, r[5:0]}, imm: 16'h0,
          immMask: 16'hffff, cycW: 6'd0, cycN: 6'd0};
    case (kind)
      0: begin
        b.push_back(PFX[sub]);
        e.op = ASD_SEG_OVERRIDE;
        e.seg = PFX_SEG[sub];
        e.chkSeg = 1'b1;
        e.full = 1'b0;
        e.cycW = 6'd2;
      end
      1: begin
        b.push_back({RM_BASE[sub], e.d, w});
        b.push_back(e.form);
        e.op = ARITH_OP[sub];
        e.chkD = 1'b1;
        e.cycW = mem ? 6'd10 : 6'd3;
      end
      2: begin
        e.form[5:3] = IMM_SEL[sub];
        b.push_back({6'b100000, s, w});
        b.push_back(e.form);
        e.op = ARITH_OP[sub];
        e.cycW = mem ? 6'd16 : 6'd4;
      end
      3: begin
        s = 1'b0;
        e.form = 8'hc0;
        e.mem = 1'b0;
        b.push_back({ACC_BASE[sub], w});
        e.op = ARITH_OP[sub];
        e.cycW = w ? 6'd4 : 6'd3;
      end
      4, 5: begin
        e.form[5:3] = (kind == 4) ? 3'b011 : 3'b100;
        b.push_back({7'b1111011, w});
        b.push_back(e.form);
        e.op = (kind == 4) ? ASD_TWOS_COMPLEMENT_NEGATE : ASD_UNSIGNED_PRODUCT;
        if (kind == 4) e.cycW = mem ? 6'd10 : 6'd3;
        else e.cycW = mem ? (w ? 6'd41 : 6'd32) : (w ? 6'd35 : 6'd26);
      end
      default: begin
        b.push_back(ADJ[sub]);
        e.op = ADJ_OP[sub];
        e.full = 1'b0;
        e.cycW = ADJ_CYC[sub];
      end
    endcase
    if (kind == 2 || kind == 3) begin
      b.push_back(r[15:8]);
      if (w && !s) b.push_back(r[23:16]);
      e.immMask = w ? 16'hffff : 16'h00ff;
      e.imm = !w ? {8'h00, r[15:8]} : (s ? {{8{r[15]}}, r[15:8]} : r[23:8]);
    end
    // the narrow bus pays once more for every word-sized memory operand
    e.cycN = e.cycW + ((e.full && w && e.mem) ? 6'd4 : 6'd0);
    foreach (b[i]) begin
      var_g[0].qm.push(b[i]);
      var_g[1].qm.push(b[i]);
    end
    nBytes += b.size();
    expList.push_back(e);
  endtask : add_instr

  function automatic logic all_done();
    return var_g[0].idx == expList.size() && var_g[1].idx == expList.size() &&
           !var_g[0].running && !var_g[1].running;
  endfunction : all_done

  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tallyAndFinish

  initial begin
    logic [31:0] r;
    for (int k = 0; k < 7; k++) begin
      for (int s = 0; s < 4; s++) begin
        for (int v = 0; v < 4; v++) begin
          add_instr(k, s, v[0], v[1], rnd());
        end
      end
    end
    for (int i = 0; i < 250; i++) begin
      r = rnd();
      add_instr(int'(r[2:0]) % 7, int'(r[4:3]), r[5], r[6], rnd());
    end
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    for (int t = 0; t < 60000 && !all_done(); t++) begin
      @(negedge core_clk);
      r = rnd();
      clkEn = (r[2:0] != 3'h0);
      slow = r[3];
    end
    if (!all_done()) begin
      numErrors++;
      $display("BAD completion expected all seen hang");
    end
    clkEn = 1'b1;
    repeat (20) @(negedge core_clk);
    cmp_val("queue_left_wide", 16'h0, 16'(var_g[0].qm.depth()));
    cmp_val("queue_left_narrow", 16'h0, 16'(var_g[1].qm.depth()));
    cmp_val("queueTake_wide", 16'(nBytes), 16'(var_g[0].takes));
    cmp_val("queueTake_narrow", 16'(nBytes), 16'(var_g[1].takes));
    tallyAndFinish();
  end
endmodule : test_arith_segment_decoder

// ==== verilog/asd_arith_segment_decoder.sv ====
`timescale 1ns/1ps
// How it works
// - four segment prefixes, two cycles each
// - add forms, register/memory, immediate, accumulator
// - add-with-carry forms and their cycle counts
// - subtract forms and their cycle counts
// - subtract-with-borrow forms and cycle counts
// - negate from unary group, reg field 011
// - ascii adjust after sum, eight cycles
// - decimal adjust after sum, four cycles
// - ascii adjust after difference, seven cycles
// - decimal adjust after difference, four cycles
// - unsigned product, reg field 100, timed
// - narrow bus adds four per word memory
// - second immediate byte only when s,w=01
module asd_arith_segment_decoder
  import asd_pkg::*;
#(
  parameter bit NARROW_BUS = 1'b0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] queueByte,
  input wire logic queueValid,
  output logic queueTake,
  output logic instrValid,
  output asd_op_type instrOp,
  output asd_seg_type segOverride,
  output logic wordOperand,
  output logic regIsDest,
  output logic memOperand,
  output logic [7:0] formByte,
  output logic [15:0] immData,
  output logic [5:0] execCycles,
  output logic execDone
);
  // ----------------------------------------------------------------
  // fetch sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ASD_ST_OPCODE = 5'b00001,
    ASD_ST_FORM = 5'b00010,
    ASD_ST_IMM_LO = 5'b00100,
    ASD_ST_IMM_HI = 5'b01000,
    ASD_ST_EXEC = 5'b10000
  } asd_state_type;

  asd_state_type state, next_state;
  logic [7:0] opcode, next_opcode;
  logic [7:0] next_formByte;
  logic [15:0] next_immData;
  asd_op_type next_instrOp;
  asd_seg_type next_segOverride;
  logic next_instrValid;
  logic [5:0] next_execCycles;
  logic timerBusy;
  logic timerDone;
  logic timerStart;
  logic take;

  // operand-form classification of the opcode held
  logic isRm, isImmGrp, isAcc, isUnary, wordBit, sxBit;
  logic [5:0] cyc;
  logic [2:0] sel;
  asd_op_type opFromForm;

  assign take = queueValid && !queueTake && timerBusy == 1'b0 && state != ASD_ST_EXEC;
  assign wordBit = opcode[0];
  assign sxBit = opcode[1];
  assign isRm = opcode[7:2] == ASD_RM_ADD || opcode[7:2] == ASD_RM_ADC
             || opcode[7:2] == ASD_RM_SUB || opcode[7:2] == ASD_RM_SBB;
  assign isImmGrp = opcode[7:2] == ASD_IMM_GRP;
  assign isAcc = opcode[7:1] == ASD_ACC_ADD || opcode[7:1] == ASD_ACC_ADC
              || opcode[7:1] == ASD_ACC_SUB || opcode[7:1] == ASD_ACC_SBB;
  assign isUnary = opcode[7:1] == ASD_UNARY_GRP;
  assign sel = formByte[5:3];

  always_comb begin
    opFromForm = ASD_ILLEGAL;
    if (isImmGrp) begin
      case (sel)
        ASD_SEL_ADD: opFromForm = ASD_SUM;
        ASD_SEL_ADC: opFromForm = ASD_SUM_CARRY;
        ASD_SEL_SUB: opFromForm = ASD_DIFFERENCE;
        ASD_SEL_SBB: opFromForm = ASD_DIFFERENCE_WITH_BORROW;
        default: opFromForm = ASD_ILLEGAL;
      endcase
    end else if (isUnary) begin
      if (sel == ASD_SEL_NEG) opFromForm = ASD_TWOS_COMPLEMENT_NEGATE;
      else if (sel == ASD_SEL_MUL) opFromForm = ASD_UNSIGNED_PRODUCT;
    end else begin
      case (opcode[7:2])
        ASD_RM_ADD: opFromForm = ASD_SUM;
        ASD_RM_ADC: opFromForm = ASD_SUM_CARRY;
        ASD_RM_SUB: opFromForm = ASD_DIFFERENCE;
        ASD_RM_SBB: opFromForm = ASD_DIFFERENCE_WITH_BORROW;
        default: opFromForm = ASD_ILLEGAL;
      endcase
    end
  end

  // execution time of the held instruction; mem from mod field
  always_comb begin
    logic mem;
    mem = formByte[7:6] != ASD_MOD_REG;
    cyc = ASD_CYC_RM_REG;
    if (isRm || (isUnary && sel == ASD_SEL_NEG)) begin
      cyc = mem ? ASD_CYC_RM_MEM : ASD_CYC_RM_REG;
    end else if (isImmGrp) begin
      cyc = mem ? ASD_CYC_IMM_MEM : ASD_CYC_IMM_REG;
    end else if (isUnary) begin
      // fastest end of each documented range; data-dependent spread not modelled
      if (mem) cyc = wordBit ? ASD_CYC_MUL_MW : ASD_CYC_MUL_MB;
      else cyc = wordBit ? ASD_CYC_MUL_RW : ASD_CYC_MUL_RB;
    end else if (isAcc) begin
      cyc = wordBit ? ASD_CYC_ACC_WORD : ASD_CYC_ACC_BYTE;
    end
    // narrow bus pays ASD_CYC_NARROW_WORD once per instruction with a word memory operand
    if (NARROW_BUS && mem && wordBit && (isRm || isImmGrp || isUnary)) begin
      cyc = cyc + ASD_CYC_NARROW_WORD;
    end
  end

  always_comb begin
    next_state = state;
    next_opcode = opcode;
    next_formByte = formByte;
    next_immData = immData;
    next_instrOp = instrOp;
    next_segOverride = segOverride;
    next_instrValid = 1'b0;
    next_execCycles = execCycles;
    timerStart = 1'b0;
    case (state)
      ASD_ST_OPCODE: begin
        if (take) begin
          next_opcode = queueByte;
          next_formByte = 8'h00;
          next_immData = 16'h0000;
          next_state = ASD_ST_EXEC;
          next_instrValid = 1'b1;
          timerStart = 1'b1;
          case (queueByte)
            ASD_PFX_CODE, ASD_PFX_STACK, ASD_PFX_DATA, ASD_PFX_EXTRA: begin
              next_instrOp = ASD_SEG_OVERRIDE;
              next_segOverride = asd_seg_type'({1'b0, 2'(queueByte[4:3] - 2'h1)});
              next_execCycles = ASD_CYC_PREFIX;
            end
            ASD_OP_ASCII_SUM: begin
              next_instrOp = ASD_ASCII_ADJUST_AFTER_SUM;
              next_execCycles = ASD_CYC_ASCII_SUM;
            end
            ASD_OP_DEC_SUM: begin
              next_instrOp = ASD_DECIMAL_ADJUST_AFTER_SUM;
              next_execCycles = ASD_CYC_DEC_ADJ;
            end
            ASD_OP_ASCII_DIFF: begin
              next_instrOp = ASD_ASCII_ADJUST_AFTER_DIFFERENCE;
              next_execCycles = ASD_CYC_ASCII_DIFF;
            end
            ASD_OP_DEC_DIFF: begin
              next_instrOp = ASD_DECIMAL_ADJUST_AFTER_DIFFERENCE;
              next_execCycles = ASD_CYC_DEC_ADJ;
            end
            default: begin
              next_instrValid = 1'b0;
              timerStart = 1'b0;
              next_state = ASD_ST_FORM;
              if (queueByte[7:1] == ASD_ACC_ADD || queueByte[7:1] == ASD_ACC_ADC
                  || queueByte[7:1] == ASD_ACC_SUB || queueByte[7:1] == ASD_ACC_SBB) begin
                next_state = ASD_ST_IMM_LO;
              end
            end
          endcase
        end
      end
      ASD_ST_FORM: begin
        if (take) begin
          next_formByte = queueByte;
          next_state = isImmGrp ? ASD_ST_IMM_LO : ASD_ST_EXEC;
        end
      end
      ASD_ST_IMM_LO: begin
        if (take) begin
          // single byte sign-extends for word width unless s,w=01
          next_immData = {(sxBit && wordBit) ? {8{queueByte[7]}} : 8'h00, queueByte};
          next_state = (wordBit && (isAcc || !sxBit)) ? ASD_ST_IMM_HI : ASD_ST_EXEC;
          if (isAcc) next_formByte = {ASD_MOD_REG, 6'h00};
        end
      end
      ASD_ST_IMM_HI: begin
        if (take) begin
          next_immData = {queueByte, immData[7:0]};
          next_state = ASD_ST_EXEC;
        end
      end
      ASD_ST_EXEC: begin
        // first pass through here after a multi-byte fetch launches the timer
        if (!timerBusy && !timerDone && !instrValid) begin
          next_instrOp = isAcc ? opFromFormAcc(opcode) : opFromForm;
          next_segOverride = ASD_SEG_NONE;
          next_execCycles = cyc;
          next_instrValid = 1'b1;
          timerStart = 1'b1;
        end else if (timerDone) begin
          next_state = ASD_ST_OPCODE;
        end
      end
      default: next_state = ASD_ST_OPCODE;
    endcase
  end

  function automatic asd_op_type opFromFormAcc(input logic [7:0] op);
    case (op[7:1])
      ASD_ACC_ADD: return ASD_SUM;
      ASD_ACC_ADC: return ASD_SUM_CARRY;
      ASD_ACC_SUB: return ASD_DIFFERENCE;
      ASD_ACC_SBB: return ASD_DIFFERENCE_WITH_BORROW;
      default: return ASD_ILLEGAL;
    endcase
  endfunction : opFromFormAcc

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= ASD_ST_OPCODE;
      opcode <= 8'h00;
      formByte <= 8'h00;
      immData <= 16'h0000;
      instrOp <= ASD_NONE;
      segOverride <= ASD_SEG_NONE;
      instrValid <= 1'b0;
      execCycles <= 6'h00;
      queueTake <= 1'b0;
      wordOperand <= 1'b0;
      regIsDest <= 1'b0;
      memOperand <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      opcode <= next_opcode;
      formByte <= next_formByte;
      immData <= next_immData;
      instrOp <= next_instrOp;
      segOverride <= next_segOverride;
      instrValid <= next_instrValid;
      execCycles <= next_execCycles;
      queueTake <= take;
      wordOperand <= next_opcode[0];
      regIsDest <= next_opcode[1] && (isRm || next_state == ASD_ST_FORM);
      memOperand <= next_formByte[7:6] != ASD_MOD_REG && next_state == ASD_ST_EXEC;
    end
  end

  asd_cycle_timer #(
    .WIDTH(6)
  ) u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(timerStart),
    .cycles(next_execCycles),
    .busy(timerBusy),
    .done(timerDone)
  );

  always_ff @(posedge core_clk) begin
    if (!reset_n) execDone <= 1'b0;
    else if (clk_en) execDone <= timerDone;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  prefix_two_cyc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    instrValid && instrOp == ASD_SEG_OVERRIDE |-> execCycles == ASD_CYC_PREFIX)
    else $error("prefix timing wrong");
  ascii_sum_cyc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    instrValid && instrOp == ASD_ASCII_ADJUST_AFTER_SUM |-> execCycles == 6'd8)
    else $error("ascii sum timing wrong");
  dec_sum_cyc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    instrValid && instrOp == ASD_DECIMAL_ADJUST_AFTER_SUM |-> execCycles == 6'd4)
    else $error("decimal sum timing wrong");
  ascii_diff_cyc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    instrValid && instrOp == ASD_ASCII_ADJUST_AFTER_DIFFERENCE |-> execCycles == 6'd7)
    else $error("ascii diff timing wrong");
  dec_diff_cyc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    instrValid && instrOp == ASD_DECIMAL_ADJUST_AFTER_DIFFERENCE |-> execCycles == 6'd4)
    else $error("decimal diff timing wrong");
  neg_cyc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    instrValid && instrOp == ASD_TWOS_COMPLEMENT_NEGATE && !NARROW_BUS
    |-> execCycles == (memOperand ? 6'd10 : 6'd3))
    else $error("negate timing wrong");
  mul_range_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    instrValid && instrOp == ASD_UNSIGNED_PRODUCT && !NARROW_BUS
    |-> execCycles >= 6'd26 && execCycles <= 6'd43)
    else $error("product timing out of range");
  done_after_a: assert property (@(posedge core_clk) disable iff (!reset_n || !clk_en)
    instrValid && instrOp == ASD_SEG_OVERRIDE |-> ##2 execDone)
    else $error("prefix did not finish in two cycles");
  acc_cyc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    instrValid && isAcc |-> execCycles == (wordOperand ? 6'd4 : 6'd3))
    else $error("accumulator timing wrong");

  prefix_c: cover property (@(posedge core_clk) instrValid && instrOp == ASD_SEG_OVERRIDE);
  imm_word_c: cover property (@(posedge core_clk) instrValid && isImmGrp && !sxBit && wordBit);
  mul_c: cover property (@(posedge core_clk) instrValid && instrOp == ASD_UNSIGNED_PRODUCT);
endmodule : asd_arith_segment_decoder

// ==== verilog/asd_cycle_timer.sv ====
`timescale 1ns/1ps
// counts down an execution time and pulses done on the final cycle
module asd_cycle_timer
  import asd_pkg::*;
#(
  parameter int WIDTH = 6
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [WIDTH-1:0] cycles,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] remain;
  logic [WIDTH-1:0] next_remain;
  logic next_busy;
  logic next_done;

  always_comb begin
    next_remain = remain;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      next_remain = cycles - WIDTH'(1);
      next_busy = 1'b1;
    end else if (busy) begin
      if (remain == WIDTH'(1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_remain = '0;
      end else begin
        next_remain = remain - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      remain <= next_remain;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule : asd_cycle_timer

// ==== verilog/asd_pkg.sv ====
package asd_pkg;
  // ----------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] ASD_PFX_CODE = 8'h2e;
  localparam logic [7:0] ASD_PFX_STACK = 8'h36;
  localparam logic [7:0] ASD_PFX_DATA = 8'h3e;
  localparam logic [7:0] ASD_PFX_EXTRA = 8'h26;
  localparam logic [7:0] ASD_OP_ASCII_SUM = 8'h37;
  localparam logic [7:0] ASD_OP_DEC_SUM = 8'h27;
  localparam logic [7:0] ASD_OP_ASCII_DIFF = 8'h3f;
  localparam logic [7:0] ASD_OP_DEC_DIFF = 8'h2f;
  // upper six bits of two-bit-suffixed opcodes
  localparam logic [5:0] ASD_RM_ADD = 6'h00;
  localparam logic [5:0] ASD_RM_ADC = 6'h04;
  localparam logic [5:0] ASD_RM_SUB = 6'h0a;
  localparam logic [5:0] ASD_RM_SBB = 6'h06;
  localparam logic [5:0] ASD_IMM_GRP = 6'h20;
  // upper seven bits of width-suffixed opcodes
  localparam logic [6:0] ASD_ACC_ADD = 7'h02;
  localparam logic [6:0] ASD_ACC_ADC = 7'h0a;
  localparam logic [6:0] ASD_ACC_SUB = 7'h16;
  localparam logic [6:0] ASD_ACC_SBB = 7'h0e;
  localparam logic [6:0] ASD_UNARY_GRP = 7'h7b;
  // addressing-form reg field selectors
  localparam logic [2:0] ASD_SEL_ADD = 3'h0;
  localparam logic [2:0] ASD_SEL_ADC = 3'h2;
  localparam logic [2:0] ASD_SEL_SBB = 3'h3;
  localparam logic [2:0] ASD_SEL_SUB = 3'h5;
  localparam logic [2:0] ASD_SEL_NEG = 3'h3;
  localparam logic [2:0] ASD_SEL_MUL = 3'h4;
  localparam logic [1:0] ASD_MOD_REG = 2'h3;
  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam logic [5:0] ASD_CYC_PREFIX = 6'd2;
  localparam logic [5:0] ASD_CYC_RM_REG = 6'd3;
  localparam logic [5:0] ASD_CYC_RM_MEM = 6'd10;
  localparam logic [5:0] ASD_CYC_IMM_REG = 6'd4;
  localparam logic [5:0] ASD_CYC_IMM_MEM = 6'd16;
  localparam logic [5:0] ASD_CYC_ACC_BYTE = 6'd3;
  localparam logic [5:0] ASD_CYC_ACC_WORD = 6'd4;
  localparam logic [5:0] ASD_CYC_ASCII_SUM = 6'd8;
  localparam logic [5:0] ASD_CYC_DEC_ADJ = 6'd4;
  localparam logic [5:0] ASD_CYC_ASCII_DIFF = 6'd7;
  localparam logic [5:0] ASD_CYC_MUL_RB = 6'd26;
  localparam logic [5:0] ASD_CYC_MUL_RW = 6'd35;
  localparam logic [5:0] ASD_CYC_MUL_MB = 6'd32;
  localparam logic [5:0] ASD_CYC_MUL_MW = 6'd41;
  localparam logic [5:0] ASD_CYC_MUL_SPREAD = 6'd2;
  localparam logic [5:0] ASD_CYC_NARROW_WORD = 6'd4;

  // ----------------------------------------------------------------
  // operation codes reported to execution
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ASD_NONE = 4'h0,
    ASD_SEG_OVERRIDE = 4'h1,
    ASD_SUM = 4'h2,
    ASD_SUM_CARRY = 4'h3,
    ASD_DIFFERENCE = 4'h4,
    ASD_DIFFERENCE_WITH_BORROW = 4'h5,
    ASD_TWOS_COMPLEMENT_NEGATE = 4'h6,
    ASD_ASCII_ADJUST_AFTER_SUM = 4'h7,
    ASD_DECIMAL_ADJUST_AFTER_SUM = 4'h8,
    ASD_ASCII_ADJUST_AFTER_DIFFERENCE = 4'h9,
    ASD_DECIMAL_ADJUST_AFTER_DIFFERENCE = 4'ha,
    ASD_UNSIGNED_PRODUCT = 4'hb,
    ASD_ILLEGAL = 4'hf
  } asd_op_type;

  typedef enum logic [2:0] {
    ASD_ONE_HOT_SEG_CODE = 3'h0,
    ASD_SEG_STACK = 3'h1,
    ASD_SEG_DATA = 3'h2,
    ASD_SEG_EXTRA = 3'h3,
    ASD_SEG_NONE = 3'h4
  } asd_seg_type;
endpackage : asd_pkg
